//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import pmd_pkg::*;

   // ==========================================================
   // stimulus, observation and bookkeeping
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic scanCfgEn = 1'b1;
   pmd_axi_req_t axiReq = '0;
   pmd_axi_rsp_t axiRsp;
   pmd_off_t modOff;
   logic sysclkNetOff;
   logic nvmAccessOff;
   logic scanOff;
   int err_count = 0;
   int total_checks = 0;
   int seed = 18;
   logic [1:0] bQ[$];
   logic [33:0] rQ[$];
   logic [7:0] shadow [6];
   logic [7:0] maskTab [6];
   logic [13:0] idxTab [6];

   // free-running 20 MHz clock
   always #25 ref_clk = ~ref_clk;

   pmd_module_disable dut_u (
      .ref_clk(ref_clk),
      .rst(rst),
      .axiReq(axiReq),
      .axiRsp(axiRsp),
      .scanCfgEn(scanCfgEn),
      .modOff(modOff),
      .sysclkNetOff(sysclkNetOff),
      .nvmAccessOff(nvmAccessOff),
      .scanOff(scanOff)
   );

   // ==========================================================
   // comparison and verdict
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen,
                  exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // a wait that ran out counts against the run and ends it
   task automatic give_up();
      err_count++;
      tally_and_finish();
   endtask

   function automatic logic [15:0] addrOf(input int i);
      return {idxTab[i], 2'b00};
   endfunction

   // answer watcher: oldest note against each handshake that appears
   always @(posedge ref_clk) begin
      if (!rst && axiRsp.bvalid && axiReq.bready) begin
         if (bQ.size() == 0) give_up();
         else check(axiRsp.bresp, bQ.pop_front());
      end
      if (!rst && axiRsp.rvalid && axiReq.rready) begin
         if (rQ.size() == 0) give_up();
         else check({axiRsp.rresp, axiRsp.rdata}, rQ.pop_front());
      end
   end

   // ==========================================================
   // bus master; each task starts one edge later so that no signal
   // is assigned twice in one time step
   task automatic axi_write(input logic [15:0] a, input logic [31:0] d,
                            input logic [3:0] s, input logic [1:0] er);
      logic awDone;
      logic wDone;
      int n;
      awDone = 1'b0;
      wDone = 1'b0;
      n = 0;
      @(posedge ref_clk);
      bQ.push_back(er);
      axiReq.awvalid <= 1'b1;
      axiReq.awaddr <= a;
      axiReq.wvalid <= 1'b1;
      axiReq.wdata <= d;
      axiReq.wstrb <= s;
      axiReq.bready <= 1'b1;
      while (!(awDone && wDone)) begin
         @(posedge ref_clk);
         if (!awDone && axiRsp.awready === 1'b1) begin
            awDone = 1'b1;
            axiReq.awvalid <= 1'b0;
         end
         if (!wDone && axiRsp.wready === 1'b1) begin
            wDone = 1'b1;
            axiReq.wvalid <= 1'b0;
         end
         n++;
         if (n > 50) give_up();
      end
      n = 0;
      while (axiRsp.bvalid !== 1'b1) begin
         @(posedge ref_clk);
         n++;
         if (n > 50) give_up();
      end
      axiReq.bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [15:0] a, input logic [33:0] er);
      int n;
      n = 0;
      @(posedge ref_clk);
      rQ.push_back(er);
      axiReq.arvalid <= 1'b1;
      axiReq.araddr <= a;
      axiReq.rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (n > 50) give_up();
      end while (axiRsp.arready !== 1'b1);
      axiReq.arvalid <= 1'b0;
      n = 0;
      while (axiRsp.rvalid !== 1'b1) begin
         @(posedge ref_clk);
         n++;
         if (n > 50) give_up();
      end
      axiReq.rready <= 1'b0;
   endtask

   // peripheral lines against the shadow copy of the registers
   task automatic check_lines();
      logic [47:0] e;
      e = {shadow[5], shadow[4], shadow[3], shadow[2], shadow[1], shadow[0]};
      check(modOff, e);
      check(sysclkNetOff, shadow[0][BIT_SYSCLK_NET]);
      check(nvmAccessOff, shadow[0][BIT_NVM]);
      check(scanOff, !scanCfgEn | shadow[0][BIT_SCANNER]);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] d;
      logic [7:0] pat [5];
      idxTab = '{IDX_SYSTEM, IDX_TIMERS, IDX_WAVEFORM, IDX_ANALOG,
                 IDX_PWM_CAPTURE, IDX_SERIAL};
      maskTab = '{MASK_SYSTEM, MASK_TIMERS, MASK_WAVEFORM, MASK_ANALOG,
                  MASK_PWM_CAPTURE, MASK_SERIAL};
      pat = '{8'h80, 8'h04, 8'h08, 8'hFF, 8'h00};
      foreach (shadow[i]) shadow[i] = RESET_VAL;
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      // scanner strap needs a few edges to settle
      repeat (10) @(posedge ref_clk);
      check_lines();
      for (int i = 0; i < 6; i++) axi_read(addrOf(i), 34'h0);
      // random bytes, upper data bits random too, never stored
      repeat (3) begin
         for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            axi_write(addrOf(i), d, 4'hF, RESP_OKAY);
            shadow[i] = d[7:0] & maskTab[i];
            check_lines();
            axi_read(addrOf(i), {RESP_OKAY, 24'h0, shadow[i]});
         end
      end
      // special system bits one at a time, then all together, ending all clear
      for (int k = 0; k < 5; k++) begin
         axi_write(addrOf(0), {24'h0, pat[k]}, 4'hF, RESP_OKAY);
         shadow[0] = pat[k];
         check_lines();
         repeat (20) @(posedge ref_clk);
      end
      for (int i = 1; i < 6; i++) begin
         axi_write(addrOf(i), 32'h0, 4'hF, RESP_OKAY);
         shadow[i] = 8'h00;
      end
      check_lines();
      repeat (8) @(posedge ref_clk);
      // low byte lane off, unmapped and misaligned places
      axi_write(addrOf(1), 32'hFF, 4'hE, RESP_OKAY);
      axi_write(16'h0000, 32'hFF, 4'hF, RESP_SLVERR);
      axi_write(addrOf(0) + 16'h1, 32'hFF, 4'hF, RESP_SLVERR);
      check_lines();
      axi_read(16'h3948, {RESP_SLVERR, 32'h0});
      axi_read(addrOf(2) + 16'h2, {RESP_SLVERR, 32'h0});
      // strap withdrawn forces the scanner off
      @(posedge ref_clk);
      scanCfgEn <= 1'b0;
      repeat (10) @(posedge ref_clk);
      check(scanOff, 1'b1);
      scanCfgEn <= 1'b1;
      repeat (10) @(posedge ref_clk);
      check(scanOff, 1'b0);
      // second reset in mid-run clears a set register
      axi_write(addrOf(1), 32'hFF, 4'hF, RESP_OKAY);
      shadow[1] = 8'hFF;
      check_lines();
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      check(modOff, 48'h0);
      rst <= 1'b0;
      repeat (10) @(posedge ref_clk);
      foreach (shadow[i]) shadow[i] = RESET_VAL;
      check_lines();
      axi_read(addrOf(1), 34'h0);
      tally_and_finish();
   end
endmodule

//--- verilog/pmd_module_disable.sv
`timescale 1ns/1ps
module pmd_module_disable (
   input wire logic ref_clk,
   input wire logic rst,
   input wire pmd_pkg::pmd_axi_req_t axiReq,
   output pmd_pkg::pmd_axi_rsp_t axiRsp,
   input wire logic scanCfgEn,
   output pmd_pkg::pmd_off_t modOff,
   output logic sysclkNetOff,
   output logic nvmAccessOff,
   output logic scanOff
);
   import pmd_pkg::*;

   // ==========================================================
   // address decode helpers

   // {hit, slot}; only word-aligned hits on the six indices
   function automatic logic [3:0] decode(
      input logic [ADDR_W-1:0] a
   );
      logic [13:0] idx;
      idx = a[ADDR_W-1:2];
      case (idx)
         IDX_SYSTEM: decode = 4'h8;
         IDX_TIMERS: decode = 4'h9;
         IDX_WAVEFORM: decode = 4'hA;
         IDX_ANALOG: decode = 4'hB;
         IDX_PWM_CAPTURE: decode = 4'hC;
         IDX_SERIAL: decode = 4'hD;
         default: decode = 4'h0;
      endcase
      if (a[1:0] != 2'h0) begin
         decode = 4'h0;
      end
   endfunction

   // implemented bits per slot
   function automatic logic [7:0] slotMask(
      input logic [2:0] s
   );
      case (s)
         3'h0: slotMask = MASK_SYSTEM;
         3'h1: slotMask = MASK_TIMERS;
         3'h2: slotMask = MASK_WAVEFORM;
         3'h3: slotMask = MASK_ANALOG;
         3'h4: slotMask = MASK_PWM_CAPTURE;
         3'h5: slotMask = MASK_SERIAL;
         default: slotMask = 8'h00;
      endcase
   endfunction

   // ==========================================================
   // state

   logic [7:0] reg_q [REG_NUM];
   logic [7:0] reg_d [REG_NUM];

   logic awRdy_q;
   logic wRdy_q;
   logic awHeld_q;
   logic wHeld_q;
   logic [ADDR_W-1:0] awAddr_q;
   logic [7:0] wData_q;
   logic wLane0_q;
   logic bValid_q;
   logic [1:0] bResp_q;
   logic arRdy_q;
   logic rValid_q;
   logic [DATA_W-1:0] rData_q;
   logic [1:0] rResp_q;

   logic scanSync1_q;
   logic scanSync2_q;
   logic scanSync3_q;
   logic cfgEn_q;

   logic sysclkNetOff_q;
   logic nvmAccessOff_q;
   logic scanOff_q;

   logic [3:0] wrDec;
   logic [3:0] rdDec;
   logic doWrite;
   logic awTake;
   logic wTake;
   logic arTake;

   // ==========================================================
   // handshake terms

   assign awTake = axiReq.awvalid & awRdy_q;
   assign wTake = axiReq.wvalid & wRdy_q;
   assign arTake = axiReq.arvalid & arRdy_q;
   assign wrDec = decode(awAddr_q);
   assign rdDec = decode(axiReq.araddr);
   // write commits once both halves are held and no answer pends
   assign doWrite = awHeld_q & wHeld_q & ~bValid_q;

   // ==========================================================
   // next register values

   // unassigned bits never store; byte lane 0 carries the data
   always_comb begin
      for (int i = 0; i < REG_NUM; i++) begin
         reg_d[i] = reg_q[i];
      end
      if (doWrite && wrDec[3] && wLane0_q) begin
         reg_d[wrDec[2:0]] = wData_q & slotMask(wrDec[2:0]);
      end
   end

   // ==========================================================
   // disable registers

   // cleared by every reset so all peripherals but the scanner start enabled
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < REG_NUM; i++) begin
            reg_q[i] <= RESET_VAL;
         end
      end else begin
         for (int i = 0; i < REG_NUM; i++) begin
            reg_q[i] <= reg_d[i];
         end
      end
   end

   // each byte drives hold-in-reset, output gate and access gate
   // of its peripherals; a cleared bit lets the peripheral come
   // out of reset with power-on values
   assign modOff.system = reg_q[0];
   assign modOff.timers = reg_q[1];
   assign modOff.waveform = reg_q[2];
   assign modOff.analog = reg_q[3];
   assign modOff.pwmCapture = reg_q[4];
   assign modOff.serial = reg_q[5];
   // system bits 6,5,4,1,0 go out unchanged in modOff.system

   // ==========================================================
   // scanner config enable, from outside the clock domain

   // three stages; only an agreeing pair of late stages counts
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         scanSync1_q <= 1'b0;
         scanSync2_q <= 1'b0;
         scanSync3_q <= 1'b0;
      end else begin
         scanSync1_q <= scanCfgEn;
         scanSync2_q <= scanSync1_q;
         scanSync3_q <= scanSync2_q;
      end
   end

   // scanner treated as not configured until the strap settles
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfgEn_q <= 1'b0;
      end else if (scanSync2_q == scanSync3_q) begin
         cfgEn_q <= scanSync3_q;
      end
   end

   // ==========================================================
   // special system controls, loaded with the register itself

   // only the full-rate network is cut; the quarter-rate clock
   // stays outside this gate so its users keep running
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sysclkNetOff_q <= 1'b0;
      end else begin
         sysclkNetOff_q <= reg_d[0][BIT_SYSCLK_NET];
      end
   end

   // blocks memory reads, writes and control register writes
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         nvmAccessOff_q <= 1'b0;
      end else begin
         nvmAccessOff_q <= reg_d[0][BIT_NVM];
      end
   end

   // an unconfigured scanner stays off whatever software writes
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         scanOff_q <= 1'b1;
      end else begin
         scanOff_q <= reg_d[0][BIT_SCANNER] | ~cfgEn_q;
      end
   end

   assign sysclkNetOff = sysclkNetOff_q;
   assign nvmAccessOff = nvmAccessOff_q;
   assign scanOff = scanOff_q;

   // ==========================================================
   // write address and data channels

   // each half is taken alone; both stay closed until bready
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         awRdy_q <= 1'b1;
         awHeld_q <= 1'b0;
         awAddr_q <= '0;
      end else begin
         if (awTake) begin
            awRdy_q <= 1'b0;
            awHeld_q <= 1'b1;
            awAddr_q <= axiReq.awaddr;
         end else if (doWrite) begin
            awHeld_q <= 1'b0;
         end else if (bValid_q && axiReq.bready) begin
            awRdy_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wRdy_q <= 1'b1;
         wHeld_q <= 1'b0;
         wData_q <= '0;
         wLane0_q <= 1'b0;
      end else begin
         if (wTake) begin
            wRdy_q <= 1'b0;
            wHeld_q <= 1'b1;
            wData_q <= axiReq.wdata[7:0];
            wLane0_q <= axiReq.wstrb[0];
         end else if (doWrite) begin
            wHeld_q <= 1'b0;
         end else if (bValid_q && axiReq.bready) begin
            wRdy_q <= 1'b1;
         end
      end
   end

   // ==========================================================
   // write response

   // unmapped or misaligned words answer SLVERR and store nothing
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bValid_q <= 1'b0;
         bResp_q <= RESP_OKAY;
      end else if (doWrite) begin
         bValid_q <= 1'b1;
         bResp_q <= wrDec[3] ? RESP_OKAY : RESP_SLVERR;
      end else if (bValid_q && axiReq.bready) begin
         bValid_q <= 1'b0;
      end
   end

   // ==========================================================
   // read channel

   // one read at a time; data registered with the valid
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         arRdy_q <= 1'b1;
         rValid_q <= 1'b0;
         rData_q <= '0;
         rResp_q <= RESP_OKAY;
      end else if (arTake) begin
         arRdy_q <= 1'b0;
         rValid_q <= 1'b1;
         if (rdDec[3]) begin
            rData_q <= {24'h000000,
               reg_q[rdDec[2:0]] & slotMask(rdDec[2:0])};
            rResp_q <= RESP_OKAY;
         end else begin
            rData_q <= '0;
            rResp_q <= RESP_SLVERR;
         end
      end else if (rValid_q && axiReq.rready) begin
         rValid_q <= 1'b0;
         arRdy_q <= 1'b1;
      end
   end

   assign axiRsp.awready = awRdy_q;
   assign axiRsp.wready = wRdy_q;
   assign axiRsp.bvalid = bValid_q;
   assign axiRsp.bresp = bResp_q;
   assign axiRsp.arready = arRdy_q;
   assign axiRsp.rvalid = rValid_q;
   assign axiRsp.rdata = rData_q;
   assign axiRsp.rresp = rResp_q;

   // ==========================================================
   // checks

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   a_write_lands: assert property (
      doWrite && wrDec == 4'h8 && wLane0_q
      |=> modOff.system == $past(wData_q))
      else $error("system write not stored");

   a_bits_hold: assert property (
      !doWrite |=> $stable(modOff))
      else $error("disable bits moved without a write");

   a_unused_zero: assert property (
      (modOff.waveform & ~MASK_WAVEFORM) == 8'h00
      && (modOff.analog & ~MASK_ANALOG) == 8'h00
      && (modOff.pwmCapture & ~MASK_PWM_CAPTURE) == 8'h00
      && (modOff.serial & ~MASK_SERIAL) == 8'h00)
      else $error("unassigned bit set");

   a_sysclk_cut: assert property (
      sysclkNetOff == modOff.system[BIT_SYSCLK_NET])
      else $error("clock network gate disagrees");

   a_nvm_block: assert property (
      nvmAccessOff == modOff.system[BIT_NVM])
      else $error("memory block disagrees");

   a_scan_gate: assert property (
      $stable(cfgEn_q) |->
      scanOff == (modOff.system[BIT_SCANNER] | !cfgEn_q))
      else $error("scanner gate wrong");

   a_resp_follow: assert property (
      doWrite |=> bValid_q
      && (bResp_q == RESP_SLVERR) == !$past(wrDec[3]))
      else $error("response did not follow write");

   a_read_narrow: assert property (
      $rose(rValid_q) |-> rData_q[31:8] == 24'h000000
      && (rResp_q == RESP_OKAY || rData_q == '0))
      else $error("read data too wide");

   a_read_wait: assert property (
      rValid_q && !axiReq.rready |=> rValid_q && $stable(rData_q))
      else $error("read answer dropped");

   c_write_ok: cover property (
      bValid_q && bResp_q == RESP_OKAY && axiReq.bready);
   c_read_err: cover property (
      rValid_q && rResp_q == RESP_SLVERR);
   c_timer_off: cover property ($rose(modOff.timers[0]));
   c_scan_on: cover property ($fell(scanOff));

endmodule

//--- verilog/pmd_pkg.sv
// How it works
// - a set disable bit holds its peripheral in reset, doing nothing
// - disabled peripheral registers ignore writes and read as 0x00
// - outputs of a disabled peripheral are forced inactive
// - every system reset clears all disable bits to zero
// - clearing a bit releases the peripheral with power-on values
// - quarter-rate clocked peripherals keep running when that network is cut
// - system register bit 2 blocks nonvolatile memory access and control
// - system bit 3 turns the scanner off, subject to its config enable
// - system bits 6,5,4,1,0 turn off vref, detector, crc, clkref, ioc
// - timers register bits 7..0 turn off timers 7..0
// - waveform bits 5,3,2,1,0: waveform gen, modulator, two meas, timer8
// - disable bits are read/write, one disabled, zero enabled
package pmd_pkg;

   // ==========================================================
   // bus shape
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;
   localparam int REG_NUM = 6;
   localparam int REG_W = 8;

   // register indices; byte address is four times the index
   localparam logic [13:0] IDX_SYSTEM = 14'h0E4C;
   localparam logic [13:0] IDX_TIMERS = 14'h0E4D;
   localparam logic [13:0] IDX_WAVEFORM = 14'h0E4E;
   localparam logic [13:0] IDX_ANALOG = 14'h0E4F;
   localparam logic [13:0] IDX_PWM_CAPTURE = 14'h0E50;
   localparam logic [13:0] IDX_SERIAL = 14'h0E51;

   // ==========================================================
   // implemented bits and reset values
   localparam logic [7:0] MASK_SYSTEM = 8'hFF;
   localparam logic [7:0] MASK_TIMERS = 8'hFF;
   localparam logic [7:0] MASK_WAVEFORM = 8'h2F;
   localparam logic [7:0] MASK_ANALOG = 8'h6F;
   localparam logic [7:0] MASK_PWM_CAPTURE = 8'h7F;
   localparam logic [7:0] MASK_SERIAL = 8'h7F;
   localparam logic [7:0] RESET_VAL = 8'h00;

   // system register fields
   localparam int BIT_SYSCLK_NET = 7;
   localparam int BIT_SCANNER = 3;
   localparam int BIT_NVM = 2;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } pmd_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } pmd_axi_rsp_t;

   // one disable byte per register, toward the peripherals
   typedef struct packed {
      logic [7:0] serial;
      logic [7:0] pwmCapture;
      logic [7:0] analog;
      logic [7:0] waveform;
      logic [7:0] timers;
      logic [7:0] system;
   } pmd_off_t;

endpackage
